//--- hw/adctc_pkg.sv
// Package: register map, field positions and constants of the transfer channel
package adctc_pkg;
  // APB byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BLKSZ = 8'h04;
  localparam logic [7:0] OFF_CNT = 8'h08;
  localparam logic [7:0] OFF_RLD = 8'h0C;
  localparam logic [7:0] OFF_SRC = 8'h10;
  localparam logic [7:0] OFF_DST = 8'h14;
  localparam logic [7:0] OFF_EN1 = 8'h18;
  localparam logic [7:0] OFF_IRQF = 8'h1C;
  localparam logic [7:0] OFF_MASK = 8'h20;
  localparam logic [7:0] OFF_CONV = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  // Field positions of channel_control and the other registers
  localparam int B_MODE = 0;
  localparam int B_RPT_SEL = 1;
  localparam int B_SRCINC = 2;
  localparam int B_DSTINC = 3;
  localparam int B_SIZE = 6;
  localparam int B_ACT_EN = 5;
  localparam int B_REQ = 0;
  localparam int B_MASK = 0;
  localparam int B_RUN = 7;
  localparam int B_TRIG = 6;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0] RST_MK = 8'hFF;
  // Converter stabilisation wait, hardware trigger wait mode
  localparam int STAB_NS = 1000;
  localparam int CLK_MHZ = 40;
  localparam int STAB_CYC = (STAB_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {ADCTC_IDLE, ADCTC_RD, ADCTC_WR, ADCTC_DONE}
    adctc_state_e;
endpackage

//--- hw/adctc_mem_if.sv
// Interface: byte memory port between channel engine and bus mover
`timescale 1ns/1ps
`default_nettype none
interface adctc_mem_if;
  logic req;
  logic wr;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport eng (output req, output wr, output addr, output wdata,
    input rdata, input ack);
  modport mov (input req, input wr, input addr, input wdata,
    output rdata, output ack);
endinterface
`default_nettype wire

//--- hw/adctc_mover.sv
// Bus mover: registers one byte access onto the memory pins
`timescale 1ns/1ps
`default_nettype none
module adctc_mover (
  input wire logic ref_clk,
  input wire logic arst_n,
  adctc_mem_if.mov mp,
  output logic mem_req,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  logic busy_reg;
  // Single outstanding access; ack from memory ends it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      mem_req <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else if (!busy_reg && mp.req) begin
      busy_reg <= 1'b1;
      mem_req <= 1'b1;
      mem_wr <= mp.wr;
      mem_addr <= mp.addr;
      mem_wdata <= mp.wdata;
    end else if (busy_reg && mem_ack) begin
      busy_reg <= 1'b0;
      mem_req <= 1'b0;
    end
  end
  // Ack is combinational so the engine sees it in the same cycle
  assign mp.ack = busy_reg && mem_ack;
  assign mp.rdata = mem_rdata;
endmodule
`default_nettype wire

//--- hw/adctc_channel.sv
// Top: A/D-triggered transfer channel with APB registers
//
// What this block does
// - Source address fixed when 0, increments when 1; ignored for repeat source.
// - Repeat select 0: destination is repeat area; 1: source is.
// - Repeat select has no effect in normal mode.
// - Mode bit 0 selects normal mode, 1 selects repeat mode.
// - Block size N moves N units; zero means 256 units.
// - Transfer count N allows N transfers; zero means 256.
// - Sixteen-bit source address feeds every block read.
// - Sixteen-bit destination address receives every block write.
// - Activation enable bit 5 lets conversion end start a transfer.
// - Activation enable clears itself on transfer end condition.
// - Request flag reads 1 while pending; software writes 0 to clear.
// - Mask bit 0 enables servicing, 1 disables it.
// - Run bit 1 starts conversion, 0 stops it.
// - Run bit reads 0 when stopped or in standby.
// - Run bit reads 1 through stabilisation wait and conversion.
// - Size bit selects 8-bit units when 0, 16-bit when 1.
// - Last counted transfer raises conversion end request instead.
// - Repeat destination steps one unit per unit moved, so N units per transfer of block size N.
`timescale 1ns/1ps
`default_nettype none
module adctc_channel #(
  parameter int STAB_CYCLES = adctc_pkg::STAB_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_end_pin,
  output logic conv_run,
  output logic conv_irq,
  output logic mem_req,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  // Wait counter is 16 bits wide and must count at least once
  if (STAB_CYCLES < 1 || STAB_CYCLES > 65535) begin : g_stab_check
    $error("STAB_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl_reg, blk_reg, cnt_reg, rld_reg, en1_reg, irqf_reg;
  logic [7:0] mask_reg, conv_reg;
  logic [15:0] src_reg, dst_reg, rpt_base_reg;
  logic [31:0] rdata_next;
  logic wr_acc, rd_acc, addr_ok;
  logic [2:0] sync_reg;
  logic ev_rise, ev_prev_reg;
  logic [15:0] stab_cnt_reg;
  adctc_pkg::adctc_state_e st_reg;
  logic [9:0] bytes_left_reg;
  logic [7:0] data_reg;
  logic blk_done, last_xfer;
  logic odd_reg, unit_end;
  logic [15:0] byte_ofs;
  adctc_mem_if mp();

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  // Bytes in one block; zero size means 256 units
  function automatic logic [9:0] blk_bytes(input logic [7:0] n,
    input logic wide);
    logic [8:0] units;
    units = (n == 8'h00) ? 9'd256 : {1'b0, n};
    blk_bytes = wide ? {units, 1'b0} : {1'b0, units};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Address step of one unit: one byte or two
  function automatic logic [15:0] unit_step(input logic w);
    unit_step = w ? 16'h0002 : 16'h0001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Conversion end input: three-stage sync, second and third agree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= 3'b000;
      ev_prev_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], conv_end_pin};
      if (sync_reg[2] == sync_reg[1]) begin
        ev_prev_reg <= sync_reg[2];
      end
    end
  end
  assign ev_rise = (sync_reg[2] == sync_reg[1]) && sync_reg[2] &&
    !ev_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine
  logic rpt_mode, rpt_src, src_inc, dst_inc, wide;
  assign rpt_mode = ctrl_reg[adctc_pkg::B_MODE];
  assign rpt_src = rpt_mode && ctrl_reg[adctc_pkg::B_RPT_SEL];
  assign src_inc = rpt_src || ctrl_reg[adctc_pkg::B_SRCINC];
  assign dst_inc = (rpt_mode && !rpt_src) || ctrl_reg[adctc_pkg::B_DSTINC];
  assign wide = ctrl_reg[adctc_pkg::B_SIZE];
  assign last_xfer = (cnt_reg == 8'h01);

  assign mp.req = (st_reg == adctc_pkg::ADCTC_RD) ||
    (st_reg == adctc_pkg::ADCTC_WR);
  assign mp.wr = (st_reg == adctc_pkg::ADCTC_WR);
  // Write to destination
  // Upper byte of a 16-bit unit sits one above the unit address
  assign byte_ofs = wide ? {15'h0000, odd_reg} : 16'h0000;
  assign mp.addr = ((st_reg == adctc_pkg::ADCTC_WR) ? dst_reg : src_reg) +
    byte_ofs;
  assign mp.wdata = data_reg;
  assign blk_done = (st_reg == adctc_pkg::ADCTC_WR) && mp.ack &&
    (bytes_left_reg == 10'h001);

  // State sequence: one byte read then write until block ends
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= adctc_pkg::ADCTC_IDLE;
      bytes_left_reg <= 10'h000;
      data_reg <= 8'h00;
    end else begin
      unique case (st_reg)
        adctc_pkg::ADCTC_IDLE: begin
          if (ev_rise && en1_reg[adctc_pkg::B_ACT_EN]) begin
            bytes_left_reg <= blk_bytes(blk_reg, wide);
            st_reg <= adctc_pkg::ADCTC_RD;
          end
        end
        adctc_pkg::ADCTC_RD: begin
          if (mp.ack) begin
            data_reg <= mp.rdata;
            st_reg <= adctc_pkg::ADCTC_WR;
          end
        end
        adctc_pkg::ADCTC_WR: begin
          if (mp.ack) begin
            bytes_left_reg <= bytes_left_reg - 10'h001;
            st_reg <= blk_done ? adctc_pkg::ADCTC_DONE :
              adctc_pkg::ADCTC_RD;
          end
        end
        adctc_pkg::ADCTC_DONE: begin
          st_reg <= adctc_pkg::ADCTC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h0000_0000;
    end
  end

  // Read mux; unmapped offsets answer with an error
  always_comb begin
    addr_ok = 1'b1;
    rdata_next = 32'h0000_0000;
    unique case (1'b1)
      hit(paddr, adctc_pkg::OFF_CTRL): rdata_next[7:0] = ctrl_reg;
      hit(paddr, adctc_pkg::OFF_BLKSZ): rdata_next[7:0] = blk_reg;
      hit(paddr, adctc_pkg::OFF_CNT): rdata_next[7:0] = cnt_reg;
      hit(paddr, adctc_pkg::OFF_RLD): rdata_next[7:0] = rld_reg;
      hit(paddr, adctc_pkg::OFF_SRC): rdata_next[15:0] = src_reg;
      hit(paddr, adctc_pkg::OFF_DST): rdata_next[15:0] = dst_reg;
      hit(paddr, adctc_pkg::OFF_EN1): rdata_next[7:0] = en1_reg;
      hit(paddr, adctc_pkg::OFF_IRQF): rdata_next[7:0] = irqf_reg;
      hit(paddr, adctc_pkg::OFF_MASK): rdata_next[7:0] = mask_reg;
      hit(paddr, adctc_pkg::OFF_CONV): rdata_next[7:0] = conv_reg;
      hit(paddr, adctc_pkg::OFF_STAT): rdata_next[1:0] = st_reg;
      default: addr_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain software registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= adctc_pkg::RST_BYTE;
      blk_reg <= adctc_pkg::RST_BYTE;
      rld_reg <= adctc_pkg::RST_BYTE;
      mask_reg <= adctc_pkg::RST_MK;
    end else if (wr_acc) begin
      if (hit(paddr, adctc_pkg::OFF_CTRL)) ctrl_reg <= pwdata[7:0];
      if (hit(paddr, adctc_pkg::OFF_BLKSZ)) blk_reg <= pwdata[7:0];
      if (hit(paddr, adctc_pkg::OFF_RLD)) rld_reg <= pwdata[7:0];
      if (hit(paddr, adctc_pkg::OFF_MASK)) mask_reg <= pwdata[7:0];
    end
  end

  // Count: hardware update beats a same-cycle software write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= adctc_pkg::RST_BYTE;
    end else if (st_reg == adctc_pkg::ADCTC_DONE) begin
      // Reload on the last transfer (count 1) in repeat mode
      if (rpt_mode && last_xfer) cnt_reg <= rld_reg;
      // Zero wraps to 255, giving 256 transfers
      else cnt_reg <= cnt_reg - 8'd1;
    end else if (wr_acc && hit(paddr, adctc_pkg::OFF_CNT)) begin
      cnt_reg <= pwdata[7:0];
    end
  end

  // Byte half of the current 16-bit unit; a block starts on the low half
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      odd_reg <= 1'b0;
    end else if (st_reg == adctc_pkg::ADCTC_IDLE) begin
      odd_reg <= 1'b0;
    end else if (st_reg == adctc_pkg::ADCTC_WR && mp.ack && wide) begin
      odd_reg <= !odd_reg;
    end
  end
  // Addresses move only once a whole unit is written
  assign unit_end = !wide || odd_reg;

  // Addresses advance per unit; repeat area restored after last block
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_reg <= adctc_pkg::RST_ADDR;
      dst_reg <= adctc_pkg::RST_ADDR;
      rpt_base_reg <= adctc_pkg::RST_ADDR;
    end else if (st_reg == adctc_pkg::ADCTC_WR && mp.ack) begin
      // Fixed address keeps reading the same unit
      if (src_inc && unit_end) src_reg <= src_reg + unit_step(wide);
      if (dst_inc && unit_end) dst_reg <= dst_reg + unit_step(wide);
    end else if (st_reg == adctc_pkg::ADCTC_DONE) begin
      if (rpt_mode && last_xfer && rpt_src) src_reg <= rpt_base_reg;
      if (rpt_mode && last_xfer && !rpt_src) dst_reg <= rpt_base_reg;
    end else if (wr_acc && hit(paddr, adctc_pkg::OFF_SRC)) begin
      src_reg <= pwdata[15:0];
      if (ctrl_reg[adctc_pkg::B_RPT_SEL]) rpt_base_reg <= pwdata[15:0];
    end else if (wr_acc && hit(paddr, adctc_pkg::OFF_DST)) begin
      dst_reg <= pwdata[15:0];
      if (!ctrl_reg[adctc_pkg::B_RPT_SEL]) rpt_base_reg <= pwdata[15:0];
    end
  end

  // Activation enable; auto clear wins over a software set
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      en1_reg <= adctc_pkg::RST_BYTE;
    end else begin
      if (wr_acc && hit(paddr, adctc_pkg::OFF_EN1)) en1_reg <= pwdata[7:0];
      if (st_reg == adctc_pkg::ADCTC_DONE && last_xfer) begin
        en1_reg[adctc_pkg::B_ACT_EN] <= 1'b0;
      end
    end
  end

  // Request flag: hardware set beats software clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqf_reg <= adctc_pkg::RST_BYTE;
    end else begin
      if (wr_acc && hit(paddr, adctc_pkg::OFF_IRQF)) irqf_reg <= pwdata[7:0];
      // Last transfer or no activation raises request
      if ((st_reg == adctc_pkg::ADCTC_DONE && last_xfer) ||
          (ev_rise && !en1_reg[adctc_pkg::B_ACT_EN])) begin
        irqf_reg[adctc_pkg::B_REQ] <= 1'b1;
      end
    end
  end

  // Interrupt output gated by mask
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= irqf_reg[adctc_pkg::B_REQ] && !mask_reg[adctc_pkg::B_MASK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter mode register and run state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_reg <= adctc_pkg::RST_BYTE;
      stab_cnt_reg <= 16'h0000;
      conv_run <= 1'b0;
    end else begin
      if (wr_acc && hit(paddr, adctc_pkg::OFF_CONV)) begin
        conv_reg <= pwdata[7:0];
        stab_cnt_reg <= 16'(STAB_CYCLES);
        conv_run <= pwdata[adctc_pkg::B_RUN] && !pwdata[adctc_pkg::B_TRIG];
      end else if (stab_cnt_reg != 16'h0000) begin
        // Wait mode: run bit already 1 during stabilisation
        stab_cnt_reg <= stab_cnt_reg - 16'h0001;
        if (stab_cnt_reg == 16'h0001) begin
          conv_run <= conv_reg[adctc_pkg::B_RUN];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  adctc_mover u_mover (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .mp(mp),
    .mem_req(mem_req),
    .mem_wr(mem_wr),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );
endmodule
`default_nettype wire

//--- testbench/adctc_channel_checker.sv
// Checker: port-level properties of the transfer channel
`timescale 1ns/1ps
`default_nettype none
module adctc_channel_checker #(
  parameter int STAB_CYCLES = adctc_pkg::STAB_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_end_pin,
  input wire logic conv_run,
  input wire logic conv_irq,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  localparam int STAB_MAX = STAB_CYCLES + 4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Completed APB writes and mode-register decodes
  logic wr_ok;
  logic adm_wr;
  assign wr_ok = psel && penable && pready && pwrite;
  assign adm_wr = wr_ok && paddr == adctc_pkg::OFF_CONV;
  sequence rd_byte_s;
    mem_req && !mem_wr && mem_ack;
  endsequence
  sequence wr_byte_s;
    ##[1:8] (mem_req && mem_wr);
  endsequence
  ////////////////////////////////////////////////////////////
  // Bus side: zero-wait answer, error only off the map
  chk_apb_answer: assert property (psel && !penable |=> pready && penable)
    else $error("pready missing after setup");
  chk_ready_phase: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_unmapped_err: assert property (pready && paddr[1:0] == 2'b00 |->
    pslverr == (paddr > adctc_pkg::OFF_STAT))
    else $error("pslverr wrong for offset");
  // Memory side: request held steady until acknowledged
  chk_mem_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_wr))
    else $error("memory request changed before ack");
  chk_read_then_write: assert property (rd_byte_s |-> wr_byte_s)
    else $error("read not followed by write");
  // Interrupt line and converter run level
  chk_mask_irq: assert property (wr_ok && paddr == adctc_pkg::OFF_MASK
    && pwdata[0] |-> ##[1:2] !conv_irq)
    else $error("masked request still drives irq");
  chk_run_start: assert property (adm_wr && pwdata[7] && !pwdata[6]
    |-> ##[1:3] conv_run)
    else $error("conversion did not start");
  chk_run_stop: assert property (adm_wr && !pwdata[7]
    |-> ##[1:3] !conv_run)
    else $error("conversion did not stop");
  chk_stab_wait: assert property (adm_wr && pwdata[7] && pwdata[6]
    |-> ##[1:STAB_MAX] conv_run)
    else $error("run level late after wait");
endmodule
bind adctc_channel adctc_channel_checker #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_end_pin(conv_end_pin),
  .conv_run(conv_run), .conv_irq(conv_irq), .mem_req(mem_req),
  .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .mem_ack(mem_ack));
`default_nettype wire

//--- testbench/adctc_mem_model.sv
// Model: byte-wide on-chip memory answering the channel's bus port
`timescale 1ns/1ps
`default_nettype none
module adctc_mem_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [0:65535];
  int wr_cnt;
  int wait_cnt;
  // Known contents everywhere, so copied data is never unknown
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
  end
  // Ack after zero or four waits; idle read data toggles, not held
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h5A;
      wr_cnt <= 0;
      wait_cnt <= 0;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= 0;
    end else if (wait_cnt < (slow ? 4 : 0)) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      mem_ack <= 1'b1;
      if (mem_wr) begin
        mem[mem_addr] <= mem_wdata;
        wr_cnt <= wr_cnt + 1;
      end else begin
        mem_rdata <= mem[mem_addr];
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/test_adctc_channel.sv
// Testbench: scenarios for the A/D-triggered transfer channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module test_adctc_channel;
  localparam int STAB = 4;
  logic ref_clk, arst_n, psel, penable, pwrite, conv_end_pin, slow;
  logic pready, pslverr, conv_run, conv_irq, mem_req, mem_wr, mem_ack;
  logic [7:0] paddr, mem_wdata, mem_rdata;
  logic [15:0] mem_addr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  int error_cnt, cmp_count, w0;
  adctc_channel #(.STAB_CYCLES(STAB)) uut (.ref_clk(ref_clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_end_pin(conv_end_pin), .conv_run(conv_run),
    .conv_irq(conv_irq), .mem_req(mem_req), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  adctc_mem_model mdl (.ref_clk(ref_clk), .arst_n(arst_n), .slow(slow),
    .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic hang;
    error_cnt++;
    $display("MISMATCH t=%0t wait ran out", $time);
    stop_test();
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (++n > 20) hang();
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic reg_rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Conversion-end level, wide enough for the input synchroniser
  task automatic fire;
    @(posedge ref_clk);
    conv_end_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    conv_end_pin <= 1'b0;
  endtask
  // Wait for the byte writes to land, then for the engine to idle
  task automatic wait_wr(input int target);
    int n;
    for (n = 0; mdl.wr_cnt < target; n++) begin
      if (n > 3000) hang();
      @(negedge ref_clk);
    end
    n = 0;
    do begin
      reg_rd(adctc_pkg::OFF_STAT);
      if (++n > 50) hang();
    end while (rd[1:0] !== 2'b00);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset_map;
    reg_rd(adctc_pkg::OFF_MASK);
    `CHK(rd[7:0], adctc_pkg::RST_MK)
    reg_rd(8'h2C);
    `CHK({err, rd}, {1'b1, 32'h0})
    reg_wr(adctc_pkg::OFF_SRC, 32'hFF1E);
    reg_rd(adctc_pkg::OFF_SRC);
    `CHK(rd[15:0], 16'hFF1E)
    reg_wr(adctc_pkg::OFF_DST, 32'hF500);
    reg_rd(adctc_pkg::OFF_DST);
    `CHK(rd[15:0], 16'hF500)
  endtask
  // Normal mode, 8-bit, both addresses stepping, repeat select set
  task automatic t_normal;
    for (int i = 0; i < 4; i++) mdl.mem[16'h1000 + i] = 8'(8'h30 + i);
    reg_wr(adctc_pkg::OFF_CTRL, 32'h0E);
    reg_wr(adctc_pkg::OFF_BLKSZ, 32'h02);
    reg_wr(adctc_pkg::OFF_CNT, 32'h02);
    reg_wr(adctc_pkg::OFF_SRC, 32'h1000);
    reg_wr(adctc_pkg::OFF_DST, 32'h2000);
    reg_wr(adctc_pkg::OFF_MASK, 32'h00);
    reg_wr(adctc_pkg::OFF_EN1, 32'h20);
    w0 = mdl.wr_cnt;
    fire();
    wait_wr(w0 + 2);
    `CHK({mdl.mem[16'h2000], mdl.mem[16'h2001]}, 16'h3031)
    reg_rd(adctc_pkg::OFF_CNT);
    `CHK(rd[7:0], 8'h01)
    slow <= 1'b1;
    fire();
    wait_wr(w0 + 4);
    `CHK({mdl.mem[16'h2002], mdl.mem[16'h2003]}, 16'h3233)
    `CHK(mdl.mem[16'h2004], 8'h24)
    reg_rd(adctc_pkg::OFF_IRQF);
    `CHK(rd[0], 1'b1)
    reg_rd(adctc_pkg::OFF_EN1);
    `CHK(rd[5], 1'b0)
    @(negedge ref_clk);
    `CHK(conv_irq, 1'b1)
    reg_wr(adctc_pkg::OFF_MASK, 32'h01);
    repeat (2) @(negedge ref_clk);
    `CHK(conv_irq, 1'b0)
    reg_wr(adctc_pkg::OFF_IRQF, 32'h00);
    reg_rd(adctc_pkg::OFF_IRQF);
    `CHK(rd[0], 1'b0)
    slow <= 1'b0;
  endtask
  // Repeat mode, 16-bit, destination as repeat area, source fixed
  task automatic t_repeat;
    reg_wr(adctc_pkg::OFF_CTRL, 32'h41);
    reg_wr(adctc_pkg::OFF_BLKSZ, 32'h01);
    reg_wr(adctc_pkg::OFF_CNT, 32'h02);
    reg_wr(adctc_pkg::OFF_RLD, 32'h02);
    reg_wr(adctc_pkg::OFF_SRC, 32'h3000);
    reg_wr(adctc_pkg::OFF_DST, 32'h4000);
    reg_wr(adctc_pkg::OFF_EN1, 32'h20);
    for (int k = 0; k < 3; k++) begin
      mdl.mem[16'h3000] = 8'(8'hA1 + k);
      mdl.mem[16'h3001] = 8'(8'hB1 + k);
      w0 = mdl.wr_cnt;
      fire();
      wait_wr(w0 + 2);
      if (k == 1) begin
        reg_rd(adctc_pkg::OFF_CNT);
        `CHK(rd[7:0], 8'h02)
        reg_rd(adctc_pkg::OFF_EN1);
        `CHK(rd[5], 1'b0)
        reg_wr(adctc_pkg::OFF_EN1, 32'h20);
      end
    end
    `CHK({mdl.mem[16'h4002], mdl.mem[16'h4003]}, 16'hA2B2)
    `CHK({mdl.mem[16'h4000], mdl.mem[16'h4001]}, 16'hA3B3)
  endtask
  // Event with activation off only raises the request flag
  task automatic t_disabled;
    int n;
    reg_wr(adctc_pkg::OFF_IRQF, 32'h00);
    reg_wr(adctc_pkg::OFF_EN1, 32'h00);
    w0 = mdl.wr_cnt;
    fire();
    n = 0;
    do begin
      reg_rd(adctc_pkg::OFF_IRQF);
      if (++n > 30) hang();
    end while (rd[0] !== 1'b1);
    `CHK(mdl.wr_cnt, w0)
  endtask
  // Block size zero moves 256 bytes and no more
  task automatic t_block_zero;
    reg_wr(adctc_pkg::OFF_CTRL, 32'h0C);
    reg_wr(adctc_pkg::OFF_BLKSZ, 32'h00);
    reg_wr(adctc_pkg::OFF_CNT, 32'h01);
    reg_wr(adctc_pkg::OFF_SRC, 32'h5000);
    reg_wr(adctc_pkg::OFF_DST, 32'h6000);
    reg_wr(adctc_pkg::OFF_EN1, 32'h20);
    w0 = mdl.wr_cnt;
    fire();
    wait_wr(w0 + 256);
    `CHK(mdl.wr_cnt, w0 + 256)
    `CHK({mdl.mem[16'h6000], mdl.mem[16'h60FF]}, 16'h50AF)
    `CHK(mdl.mem[16'h6100], 8'h61)
  endtask
  // Repeat mode, source as repeat area, source control bit left at 0
  task automatic t_src_repeat;
    mdl.mem[16'h7000] = 8'h5C;
    mdl.mem[16'h7001] = 8'hC5;
    reg_wr(adctc_pkg::OFF_CTRL, 32'h0B);
    reg_wr(adctc_pkg::OFF_BLKSZ, 32'h01);
    reg_wr(adctc_pkg::OFF_CNT, 32'h02);
    reg_wr(adctc_pkg::OFF_RLD, 32'h02);
    reg_wr(adctc_pkg::OFF_SRC, 32'h7000);
    reg_wr(adctc_pkg::OFF_DST, 32'h7100);
    reg_wr(adctc_pkg::OFF_EN1, 32'h20);
    for (int k = 0; k < 2; k++) begin
      w0 = mdl.wr_cnt;
      fire();
      wait_wr(w0 + 1);
    end
    `CHK({mdl.mem[16'h7100], mdl.mem[16'h7101]}, 16'h5CC5)
    reg_rd(adctc_pkg::OFF_SRC);
    `CHK(rd[15:0], 16'h7000)
  endtask
  // Run bit in software and in hardware-trigger-wait mode
  task automatic t_conv;
    reg_wr(adctc_pkg::OFF_CONV, 32'h80);
    reg_rd(adctc_pkg::OFF_CONV);
    `CHK(rd[7], 1'b1)
    `CHK(conv_run, 1'b1)
    reg_wr(adctc_pkg::OFF_CONV, 32'h00);
    reg_rd(adctc_pkg::OFF_CONV);
    `CHK({rd[7], conv_run}, 2'b00)
    reg_wr(adctc_pkg::OFF_CONV, 32'hC0);
    reg_rd(adctc_pkg::OFF_CONV);
    `CHK(rd[7], 1'b1)
    repeat (STAB + 4) @(negedge ref_clk);
    `CHK(conv_run, 1'b1)
    reg_wr(adctc_pkg::OFF_CONV, 32'h00);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {arst_n, psel, penable, pwrite, conv_end_pin, slow} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset_map();
    t_normal();
    t_repeat();
    t_disabled();
    t_block_zero();
    t_src_repeat();
    t_conv();
    stop_test();
  end
endmodule
`default_nettype wire
